/* File: common/drs_pkg.sv */
// Package for the drive run sequencer: register map, field layout, timing
// constants, sequence states and the structs that carry pins and state.
// Assumes a single 40 MHz system clock and an APB register bus.
package drs_pkg;

   // Clock and timer base
   localparam int CLK_PERIOD_NS  = 25;
   localparam int TICK_PERIOD_NS = 100000000;             // 0.1 s timer tick
   localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int TICKS_PER_S    = 1000000000 / TICK_PERIOD_NS;
   localparam int FAN_HOLD_S     = 60;
   localparam logic [9:0] FAN_HOLD_TICKS = 10'(FAN_HOLD_S * TICKS_PER_S);

   // Contactor wait limit, in tenths of a second
   localparam logic [6:0] CWAIT_MIN   = 7'h0A;            // 1.0 s
   localparam logic [6:0] CWAIT_MAX   = 7'h64;            // 10.0 s
   localparam logic [6:0] CWAIT_RESET = 7'h64;            // 10.0 s

   // Register byte offsets
   localparam logic [7:0] ADDR_CTRL       = 8'h00;
   localparam logic [7:0] ADDR_CWAIT      = 8'h04;
   localparam logic [7:0] ADDR_STATUS     = 8'h08;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [7:0] ADDR_IRQ_CLEAR  = 8'h10;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h14;

   // Control register fields
   localparam int CTRL_START_ALLOW = 0;
   localparam int CTRL_TRIP_RESET  = 1;
   localparam logic CTRL_START_ALLOW_RESET = 1'b0;

   // Status register fields
   localparam int STAT_CODE_LSB   = 0;
   localparam int STAT_PERMITTED  = 4;
   localparam int STAT_OPERABLE   = 5;
   localparam int STAT_REVERSE    = 6;
   localparam int STAT_DRIVE_OK   = 7;
   localparam int STAT_FAN        = 8;
   localparam int STAT_CONTACTOR  = 9;
   localparam int STAT_CFB_FAULT  = 10;

   // Interrupt bits, shared by status, clear and enable registers
   localparam int IRQ_W        = 3;
   localparam int IRQ_TRIP     = 0;
   localparam int IRQ_CFB      = 1;
   localparam int IRQ_READY    = 2;

   // Number of synchroniser clocks before the frame strap is valid
   localparam logic [1:0] STRAP_SETTLE = 2'h2;

   // Sequence states, in code order 0..7
   typedef enum logic [2:0] {
      SEQ_START_DISABLED,
      SEQ_START_ENABLED,
      SEQ_ENERGISED,
      SEQ_READY,
      SEQ_ENABLED,
      SEQ_FSTOP_ACTIVE,
      SEQ_TRIP_ACTIVE,
      SEQ_TRIPPED
   } drs_seq_type;

   // Pin inputs from the drive and the contactor
   typedef struct packed {
      logic run;          // Run command
      logic run_reverse;  // Reverse run request
      logic remote_rev;   // Remote direction request
      logic contactor_fb; // Contactor closed feedback
      logic hs_hot;       // Heatsink hot
      logic amb_high;     // Ambient high
      logic load_high;    // Motor load high
      logic ext_trip;     // Trip condition present
      logic fast_stop;    // Fast stop request
      logic enable;       // Drive enable
      logic frame_var;    // Frame variant strap
   } drs_pins_type;

   localparam int PINS_W = $bits(drs_pins_type);

   // Status flags driven out of the block
   typedef struct packed {
      logic [2:0] sequence_state_code;
      logic       start_permitted_flag;
      logic       operable_flag;
      logic       reverse_demand_flag;
      logic       drive_ok_flag;
      logic       fan_demand;
      logic       contactor_cmd;
      logic       contactor_feedback_fault;
   } drs_flags_type;

   // Whole state of the sequencer
   typedef struct packed {
      drs_seq_type  seq;
      logic [6:0]   cwait;
      logic [6:0]   cwait_limit;
      logic [9:0]   fan_hold;
      logic [1:0]   settle;
      logic         strap_done;
      logic         start_allow;
      logic         trip_reset;
      logic [IRQ_W-1:0] irq_status;
      logic [IRQ_W-1:0] irq_enable;
      logic [31:0]  prdata;
      logic         pslverr;
      drs_flags_type flags;
   } drs_state_type;

endpackage

/* File: hw/drs_sync.sv */
// Two-stage synchroniser for the asynchronous pin inputs.
// Assumes the inputs may change at any time relative to i_mclk.
`timescale 1ns/1ps
module drs_sync
   import drs_pkg::*;
(
   input  wire logic              i_mclk,
   input  wire logic              i_reset_n,
   input  wire logic [PINS_W-1:0] i_async,
   output logic      [PINS_W-1:0] o_sync
);
   import drs_pkg::*;

   typedef struct packed {
      logic [PINS_W-1:0] meta;
      logic [PINS_W-1:0] stable;
   } drs_sync_state_type;

   drs_sync_state_type sync_ff;
   drs_sync_state_type nxt_sync;

   // First stage feeds only the second
   always_comb begin
      nxt_sync.meta   = i_async;
      nxt_sync.stable = sync_ff.meta;
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         sync_ff <= '0;
      end else begin
         sync_ff <= nxt_sync;
      end
   end

   assign o_sync = sync_ff.stable;
endmodule

/* File: hw/drs_tick.sv */
// Periodic timer tick: one-cycle pulse every TICK_CYCLES clocks.
// Assumes the caller shortens TICK_CYCLES in simulation if needed.
`timescale 1ns/1ps
module drs_tick
   import drs_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)(
   input  wire logic i_mclk,
   input  wire logic i_reset_n,
   output logic      o_tick
);
   import drs_pkg::*;

   typedef struct packed {
      logic [31:0] count;
      logic        tick;
   } drs_tick_state_type;

   drs_tick_state_type tick_ff;
   drs_tick_state_type nxt_tick;

   // Free-running divider, pulse registered so it is glitch free
   always_comb begin
      nxt_tick = tick_ff;
      nxt_tick.tick = 1'b0;
      if (tick_ff.count >= 32'(TICK_CYCLES_P - 1)) begin
         nxt_tick.count = '0;
         nxt_tick.tick  = 1'b1;
      end else begin
         nxt_tick.count = tick_ff.count + 32'h1;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         tick_ff <= '0;
      end else begin
         tick_ff <= nxt_tick;
      end
   end

   assign o_tick = tick_ff.tick;
endmodule

/* File: hw/drs_sequencer.sv */
// Drive run sequencer: sequence state, contactor control and timing,
// status flags, fan demand with hold, APB registers and interrupt.
// Assumes asynchronous pin inputs and an APB master on i_mclk.
`timescale 1ns/1ps
module drs_sequencer
   import drs_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)(
   input  wire logic          i_mclk,
   input  wire logic          i_reset_n,
   input  drs_pkg::drs_pins_type i_pins,
   input  wire logic          i_psel,
   input  wire logic          i_penable,
   input  wire logic          i_pwrite,
   input  wire logic [7:0]    i_paddr,
   input  wire logic [31:0]   i_pwdata,
   output logic [31:0]        o_prdata,
   output logic               o_pready,
   output logic               o_pslverr,
   output drs_pkg::drs_flags_type o_flags,
   output logic               o_irq
);
   import drs_pkg::*;

   drs_state_type st_ff;
   drs_state_type nxt_st;
   drs_pins_type  pins_s;
   logic [PINS_W-1:0] pins_sync;
   logic          tick;

   // Pins are asynchronous, so every one passes two flops
   drs_sync u_sync (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .i_async   (i_pins),
      .o_sync    (pins_sync)
   );

   assign pins_s = drs_pins_type'(pins_sync);

   drs_tick #(
      .TICK_CYCLES_P (TICK_CYCLES_P)
   ) u_tick (
      .i_mclk    (i_mclk),
      .i_reset_n (i_reset_n),
      .o_tick    (tick)
   );

   // APB decode: zero wait states, read data captured in the setup cycle
   // The bus never stalls, so a master needs no wait-state logic
   // for this block; pready is simply the access phase itself.
   logic setup_ph;
   logic wr_acc;
   logic mapped;
   assign setup_ph = i_psel && !i_penable;
   assign wr_acc   = i_psel && i_penable && i_pwrite;

   always_comb begin
      case (i_paddr)
         ADDR_CTRL, ADDR_CWAIT, ADDR_STATUS,
         ADDR_IRQ_STATUS, ADDR_IRQ_CLEAR, ADDR_IRQ_ENABLE: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   // Event and condition terms used by the sequencer
   // All that read pins use the synchronised ones, so every decision in
   // one cycle sees the same settled value of each pin.
   logic fan_cond;
   logic cwait_expired;
   logic trip_event;
   logic cfb_trip;
   logic enter_ready;
   logic [6:0] wr_limit;

   assign fan_cond = pins_s.hs_hot | pins_s.amb_high
                   | pins_s.load_high;
   assign cwait_expired = (st_ff.cwait >= st_ff.cwait_limit);
   assign cfb_trip = (st_ff.seq == SEQ_ENERGISED)
                   && !pins_s.contactor_fb && cwait_expired;
   assign trip_event = (st_ff.seq != SEQ_TRIP_ACTIVE)
                     && (st_ff.seq != SEQ_TRIPPED)
                     && (pins_s.ext_trip || cfb_trip);
   assign enter_ready = (st_ff.seq == SEQ_ENERGISED)
                      && pins_s.contactor_fb && !trip_event;

   // Out-of-range delays are clamped rather than refused
   // Software reads back the value applied, not the value written,
   // so a bad write is visible without an error response.
   always_comb begin
      if (i_pwdata[6:0] < CWAIT_MIN) begin
         wr_limit = CWAIT_MIN;
      end else if (i_pwdata[6:0] > CWAIT_MAX) begin
         wr_limit = CWAIT_MAX;
      end else begin
         wr_limit = i_pwdata[6:0];
      end
   end

   // Next-state logic for the whole block
   // Every field holds by default; trip reset is a one-cycle pulse
   // that falls again on the next edge by itself.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.trip_reset = 1'b0;

      // Sequence state machine
      case (st_ff.seq)
         SEQ_START_DISABLED: begin
            if (st_ff.start_allow && !pins_s.run) begin
               nxt_st.seq = SEQ_START_ENABLED;
            end
         end
         SEQ_START_ENABLED: begin
            if (!st_ff.start_allow) begin
               nxt_st.seq = SEQ_START_DISABLED;
            end else if (pins_s.run) begin
               nxt_st.seq   = SEQ_ENERGISED;
               nxt_st.cwait = '0;
            end
         end
         SEQ_ENERGISED: begin
            // Feedback is tested first, so a contact closing on the
            // limit tick itself still counts as closed in time
            if (pins_s.contactor_fb) begin
               nxt_st.seq = SEQ_READY;
            end else if (!pins_s.run) begin
               nxt_st.seq = SEQ_START_ENABLED;
            end else if (tick && !cwait_expired) begin
               nxt_st.cwait = st_ff.cwait + 7'h01;
            end
         end
         SEQ_READY: begin
            if (!pins_s.run) begin
               nxt_st.seq = SEQ_START_ENABLED;
            end else if (pins_s.enable) begin
               nxt_st.seq = SEQ_ENABLED;
            end
         end
         SEQ_ENABLED: begin
            if (pins_s.fast_stop) begin
               nxt_st.seq = SEQ_FSTOP_ACTIVE;
            end else if (!pins_s.run) begin
               nxt_st.seq = SEQ_START_ENABLED;
            end else if (!pins_s.enable) begin
               nxt_st.seq = SEQ_READY;
            end
         end
         SEQ_FSTOP_ACTIVE: begin
            // Stay stopped until both stop and run are withdrawn
            if (!pins_s.fast_stop && !pins_s.run) begin
               nxt_st.seq = SEQ_START_DISABLED;
            end
         end
         SEQ_TRIP_ACTIVE: begin
            if (!pins_s.ext_trip) begin
               nxt_st.seq = SEQ_TRIPPED;
            end
         end
         SEQ_TRIPPED: begin
            // A reset with run still present would restart at once
            if (st_ff.trip_reset && !pins_s.run) begin
               nxt_st.seq = SEQ_START_DISABLED;
               nxt_st.flags.contactor_feedback_fault = 1'b0;
            end else if (pins_s.ext_trip) begin
               nxt_st.seq = SEQ_TRIP_ACTIVE;
            end
         end
         default: begin
            nxt_st.seq = SEQ_START_DISABLED;
         end
      endcase

      // Any trip overrides the state machine
      // Trip states ignore a new trip, so the recorded cause and the
      // interrupt of the first trip are kept until reset by software.
      if (trip_event) begin
         nxt_st.seq = SEQ_TRIP_ACTIVE;
         if (cfb_trip) begin
            nxt_st.flags.contactor_feedback_fault = 1'b1;
         end
      end

      // Flags derived from the next state so they track it exactly
      // This costs some logic depth, but code and flags can never
      // disagree for a cycle.
      nxt_st.flags.sequence_state_code = nxt_st.seq;
      nxt_st.flags.start_permitted_flag =
         (nxt_st.seq == SEQ_START_ENABLED);
      nxt_st.flags.operable_flag =
         (nxt_st.seq == SEQ_READY)
         || (nxt_st.seq == SEQ_ENABLED);
      nxt_st.flags.contactor_cmd =
         (nxt_st.seq == SEQ_ENERGISED)
         || (nxt_st.seq == SEQ_READY)
         || (nxt_st.seq == SEQ_ENABLED)
         || (nxt_st.seq == SEQ_FSTOP_ACTIVE);

      // Demanded direction only; no speed feedback is read here
      nxt_st.flags.reverse_demand_flag =
         pins_s.remote_rev ^ pins_s.run_reverse;

      // Drive ok: trip wins over run removal in the same cycle
      if (trip_event) begin
         nxt_st.flags.drive_ok_flag = 1'b0;
      end else if (!pins_s.run) begin
         nxt_st.flags.drive_ok_flag = 1'b1;
      end

      // Fan hold timer, reloaded while any condition is present
      // The first tick may follow at once, so the hold lasts between
      // 599 and 600 tick periods after the conditions clear.
      if (fan_cond) begin
         nxt_st.fan_hold = FAN_HOLD_TICKS;
      end else if (tick && (st_ff.fan_hold != '0)) begin
         nxt_st.fan_hold = st_ff.fan_hold - 10'h001;
      end

      // Strap is read only once the synchroniser holds its value
      if (!st_ff.strap_done) begin
         if (st_ff.settle == STRAP_SETTLE) begin
            nxt_st.strap_done = 1'b1;
            if (pins_s.frame_var) begin
               nxt_st.fan_hold = FAN_HOLD_TICKS;
            end
         end else begin
            nxt_st.settle = st_ff.settle + 2'h1;
         end
      end
      nxt_st.flags.fan_demand = fan_cond
                              || (nxt_st.fan_hold != '0);

      // Register writes take effect at the access edge
      if (wr_acc) begin
         case (i_paddr)
            ADDR_CTRL: begin
               nxt_st.start_allow = i_pwdata[CTRL_START_ALLOW];
               nxt_st.trip_reset  = i_pwdata[CTRL_TRIP_RESET];
            end
            ADDR_CWAIT: begin
               nxt_st.cwait_limit = wr_limit;
            end
            ADDR_IRQ_CLEAR: begin
               nxt_st.irq_status = st_ff.irq_status
                                 & ~i_pwdata[IRQ_W-1:0];
            end
            ADDR_IRQ_ENABLE: begin
               nxt_st.irq_enable = i_pwdata[IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // Sticky events, applied after the clear so a set wins
      // Software acknowledging an old event can therefore never lose
      // a new one that arrives in the same cycle.
      if (trip_event) begin
         nxt_st.irq_status[IRQ_TRIP] = 1'b1;
      end
      if (cfb_trip) begin
         nxt_st.irq_status[IRQ_CFB] = 1'b1;
      end
      if (enter_ready) begin
         nxt_st.irq_status[IRQ_READY] = 1'b1;
      end

      // Read data captured in the setup cycle, held through access
      // Capturing early lets prdata come straight from a flop; the
      // value returned is the one held at the setup edge.
      if (setup_ph) begin
         nxt_st.pslverr = !mapped;
         nxt_st.prdata  = '0;
         case (i_paddr)
            ADDR_CTRL: begin
               nxt_st.prdata[CTRL_START_ALLOW] = st_ff.start_allow;
            end
            ADDR_CWAIT: begin
               nxt_st.prdata[6:0] = st_ff.cwait_limit;
            end
            ADDR_STATUS: begin
               nxt_st.prdata[STAT_CODE_LSB +: 3] =
                  st_ff.flags.sequence_state_code;
               nxt_st.prdata[STAT_PERMITTED] =
                  st_ff.flags.start_permitted_flag;
               nxt_st.prdata[STAT_OPERABLE] = st_ff.flags.operable_flag;
               nxt_st.prdata[STAT_REVERSE] =
                  st_ff.flags.reverse_demand_flag;
               nxt_st.prdata[STAT_DRIVE_OK] = st_ff.flags.drive_ok_flag;
               nxt_st.prdata[STAT_FAN] = st_ff.flags.fan_demand;
               nxt_st.prdata[STAT_CONTACTOR] = st_ff.flags.contactor_cmd;
               nxt_st.prdata[STAT_CFB_FAULT] =
                  st_ff.flags.contactor_feedback_fault;
            end
            ADDR_IRQ_STATUS: begin
               nxt_st.prdata[IRQ_W-1:0] = st_ff.irq_status;
            end
            ADDR_IRQ_ENABLE: begin
               nxt_st.prdata[IRQ_W-1:0] = st_ff.irq_enable;
            end
            default: begin
            end
         endcase
      end
   end

   // State register; reset values are all constants
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n) begin
         st_ff <= '0;
         st_ff.seq <= SEQ_START_DISABLED;
         st_ff.cwait_limit <= CWAIT_RESET;
         st_ff.start_allow <= CTRL_START_ALLOW_RESET;
         st_ff.flags.drive_ok_flag <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Outputs: handshake combinational, data from flops
   // The interrupt is a level; it drops only when software clears
   // the status bit or its enable.
   assign o_pready  = i_psel && i_penable;
   assign o_prdata  = st_ff.prdata;
   assign o_pslverr = st_ff.pslverr && i_psel && i_penable;
   assign o_flags   = st_ff.flags;
   assign o_irq     = |(st_ff.irq_status & st_ff.irq_enable);
endmodule

/* File: dv/drs_monitor.sv */
// Port checker for the run sequencer, bound into every drs_sequencer.
// Assumes pins reach the flags three clock edges after they change.
`timescale 1ns/1ps
module drs_monitor
   import drs_pkg::*;
#(
   parameter int TICK_CYCLES_P = TICK_CYCLES
)(
   input  wire logic             i_mclk,
   input  wire logic             i_reset_n,
   input  drs_pkg::drs_pins_type i_pins,
   input  wire logic             i_psel,
   input  wire logic             i_penable,
   input  wire logic             i_pwrite,
   input  wire logic [7:0]       i_paddr,
   input  wire logic [31:0]      i_pwdata,
   input  wire logic [31:0]      o_prdata,
   input  wire logic             o_pready,
   input  wire logic             o_pslverr,
   input  drs_pkg::drs_flags_type o_flags,
   input  wire logic             o_irq
);
   import drs_pkg::*;
   localparam int HOLD_LO = (int'(FAN_HOLD_TICKS) - 1) * TICK_CYCLES_P;
   localparam int HOLD_HI = (int'(FAN_HOLD_TICKS) + 1) * TICK_CYCLES_P + 8;
   localparam int WAIT_HI = (int'(CWAIT_MAX) + 1) * TICK_CYCLES_P + 8;
   localparam int WAIT_LO = (int'(CWAIT_MIN) - 1) * TICK_CYCLES_P;
   logic [2:0]  code;
   logic        hot;
   logic        rev_req;
   logic [31:0] quiet_ff;
   logic [31:0] ener_ff;

   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_reset_n);

   assign code = o_flags.sequence_state_code;
   assign hot = i_pins.hs_hot | i_pins.amb_high | i_pins.load_high;
   assign rev_req = i_pins.remote_rev ^ i_pins.run_reverse;

   // Spans run to thousands of cycles, so they are counted, not repeated
   always_ff @(posedge i_mclk) begin
      if (!i_reset_n || hot)
         quiet_ff <= '0;
      else
         quiet_ff <= quiet_ff + 32'h1;
      if (!i_reset_n || code < 3'h2)
         ener_ff <= '0;
      else if (code == 3'h2)
         ener_ff <= ener_ff + 32'h1; // Held after leaving, for the trip
   end

   a_energised_closes: assert property (
      code == 3'h2 |-> o_flags.contactor_cmd)
      else $error("contactor open while energised");
   a_trip_opens: assert property (
      code == 3'h6 |-> !o_flags.contactor_cmd)
      else $error("contactor closed in trip");
   a_ready_needs_fb: assert property (
      code == 3'h3 && $past(code) == 3'h2 |-> $past(i_pins.contactor_fb, 2)
      || $past(i_pins.contactor_fb, 3) || $past(i_pins.contactor_fb, 4))
      else $error("ready without contactor feedback");
   a_fault_trips: assert property (
      $rose(o_flags.contactor_feedback_fault) |-> code == 3'h6
      && $past(code) == 3'h2 && ener_ff >= WAIT_LO)
      else $error("contactor fault at wrong time");
   a_wait_limit: assert property (
      code == 3'h2 |-> ener_ff <= WAIT_HI)
      else $error("energised beyond the wait limit");
   a_permit_state: assert property (
      o_flags.start_permitted_flag == (code == 3'h1))
      else $error("start permitted flag wrong");
   a_trip_clears_ok: assert property (
      code == 3'h6 && $past(code) < 3'h6 |-> !o_flags.drive_ok_flag)
      else $error("drive ok still set on trip");
   a_ok_needs_stop: assert property (
      $rose(o_flags.drive_ok_flag) |-> !$past(i_pins.run, 2)
      || !$past(i_pins.run, 3) || !$past(i_pins.run, 4))
      else $error("drive ok set with run held");
   a_reverse_demand: assert property (
      ($stable(rev_req)) [*5] |-> o_flags.reverse_demand_flag == rev_req)
      else $error("reverse demand wrong");
   a_fan_on_cond: assert property (
      hot [*5] |-> o_flags.fan_demand)
      else $error("fan off while a condition holds");
   a_fan_hold_min: assert property (
      $fell(o_flags.fan_demand) |-> quiet_ff >= HOLD_LO)
      else $error("fan hold too short");
   a_fan_hold_max: assert property (
      quiet_ff > HOLD_HI |-> !o_flags.fan_demand)
      else $error("fan hold too long");

   c_ready: cover property (code == 3'h3);
   c_fault: cover property ($rose(o_flags.contactor_feedback_fault));
   c_fan_off: cover property ($fell(o_flags.fan_demand));
endmodule

bind drs_sequencer drs_monitor #(.TICK_CYCLES_P(TICK_CYCLES_P)) mon_u (
   .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_pins(i_pins),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
   .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .o_flags(o_flags),
   .o_irq(o_irq));

/* File: dv/drs_contactor_model.sv */
// Output contactor with its closed feedback contact.
// Assumes the feedback line reads low while the contact is open.
`timescale 1ns/1ps
module drs_contactor_model (
   input  wire logic       i_mclk,
   input  wire logic       i_cmd,
   input  wire logic [1:0] i_mode,
   output logic            o_fb
);
   int unsigned cnt = 0;

   initial o_fb = 1'b0;

   // Mode 0 closes on the 4th edge with the command high, 1 on the 81st, 2 is stuck open
   always @(posedge i_mclk) begin
      if (!i_cmd) begin
         cnt <= 0;
         o_fb <= 1'b0;
      end else begin
         cnt <= cnt + 1;
         if (i_mode != 2'h2 && cnt >= (i_mode == 2'h0 ? 3 : 80))
            o_fb <= 1'b1;
      end
   end
endmodule

/* File: dv/drs_tb.sv */
// Self-checking bench for drs_sequencer with a contactor model.
// Assumes a shortened timer tick so the 60 s fan hold fits the run.
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
   n_errors++; $display("[ERR] %0t got %0h want %0h", $time, a, e); end end
module tb;
   import drs_pkg::*;
   localparam int T = 20;
   logic          i_mclk = 1'b0;
   logic          i_reset_n = 1'b0;
   drs_pins_type  pd = '0;
   drs_pins_type  pins;
   logic          psel = 1'b0;
   logic          pen = 1'b0;
   logic          pwr = 1'b0;
   logic [7:0]    pa = '0;
   logic [31:0]   pwd = '0;
   logic [31:0]   prd, rd;
   logic          prdy, perr, irq, fb, err;
   logic [1:0]    mode = 2'h0;
   drs_flags_type fl;
   int            n_errors = 0;
   int            num_checks = 0;

   always #12.5 i_mclk = ~i_mclk;

   // Feedback comes from the model, the other pins from the bench
   always_comb begin
      pins = pd;
      pins.contactor_fb = fb;
   end

   drs_sequencer #(.TICK_CYCLES_P(T)) dut_u (
      .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_pins(pins),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(pa),
      .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
      .o_pslverr(perr), .o_flags(fl), .o_irq(irq));
   drs_contactor_model ctr_u (.i_mclk(i_mclk), .i_cmd(fl.contactor_cmd),
      .i_mode(mode), .o_fb(fb));

   task automatic print_verdict;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge i_mclk);
   endtask

   // One transfer; request held until pready is seen at a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_mclk);
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge i_mclk);
      pen <= 1'b1;
      do @(posedge i_mclk); while (prdy !== 1'b1 && ++n < 20);
      rd = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      `CHK(prdy, 1'b1)
      cyc(1);
   endtask

   task automatic wait_code(input logic [2:0] c, input int lim);
      int n;
      n = 0;
      while (fl.sequence_state_code !== c && n++ < lim)
         @(negedge i_mclk);
      `CHK(fl.sequence_state_code, c)
   endtask

   initial begin
      repeat (40000) @(posedge i_mclk);
      n_errors++;
      print_verdict();
   end

   initial begin
      repeat (6) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      cyc(8);
      `CHK(fl, 10'h008)
      apb(1'b0, ADDR_CWAIT, '0);
      `CHK(rd, 32'h64)
      apb(1'b0, 8'h40, '0);
      `CHK({err, rd}, 33'h100000000)
      apb(1'b1, ADDR_CWAIT, 32'h7F);
      apb(1'b0, ADDR_CWAIT, '0);
      `CHK(rd, 32'h64)
      apb(1'b1, ADDR_CWAIT, 32'h5);
      apb(1'b0, ADDR_CWAIT, '0);
      `CHK(rd, 32'hA)
      apb(1'b1, ADDR_IRQ_ENABLE, 32'h7);
      apb(1'b1, ADDR_CTRL, 32'h1);
      wait_code(3'h1, 10);
      @(posedge i_mclk);
      pd.run <= 1'b1;
      wait_code(3'h2, 10);
      wait_code(3'h3, 20);
      `CHK(fl.operable_flag, 1'b1)
      `CHK(irq, 1'b1)
      apb(1'b1, ADDR_IRQ_CLEAR, 32'h4);
      `CHK(irq, 1'b0)
      @(posedge i_mclk);
      pd.enable <= 1'b1;
      wait_code(3'h4, 10);
      @(posedge i_mclk);
      pd.run <= 1'b0;
      pd.enable <= 1'b0;
      wait_code(3'h1, 10);
      // Stuck contactor: trip after the 1.0 s floor, cause recorded
      apb(1'b1, ADDR_IRQ_ENABLE, 32'h1);
      @(posedge i_mclk);
      mode <= 2'h2;
      pd.run <= 1'b1;
      wait_code(3'h6, 12 * T);
      wait_code(3'h7, 8);
      `CHK(fl[3:0], 4'h1)
      apb(1'b0, ADDR_STATUS, '0);
      `CHK(rd, 32'h407)
      apb(1'b0, ADDR_IRQ_STATUS, '0);
      `CHK(rd[2:0], 3'h3)
      `CHK(irq, 1'b1)
      apb(1'b1, ADDR_IRQ_ENABLE, '0);
      `CHK(irq, 1'b0)
      apb(1'b1, ADDR_IRQ_CLEAR, 32'h3);
      apb(1'b0, ADDR_IRQ_STATUS, '0);
      `CHK(rd[2:0], 3'h0)
      `CHK(fl.drive_ok_flag, 1'b0)
      @(posedge i_mclk);
      pd.run <= 1'b0;
      cyc(5);
      `CHK(fl.drive_ok_flag, 1'b1)
      apb(1'b1, ADDR_CTRL, 32'h3);
      wait_code(3'h1, 10);
      `CHK(fl.contactor_feedback_fault, 1'b0)
      // Slow contactor, then an outside trip while ready
      @(posedge i_mclk);
      mode <= 2'h1;
      pd.run <= 1'b1;
      wait_code(3'h3, 150);
      @(posedge i_mclk);
      pd.ext_trip <= 1'b1;
      wait_code(3'h6, 8);
      `CHK(fl[3:1], 3'h0)
      @(posedge i_mclk);
      pd.ext_trip <= 1'b0;
      pd.run <= 1'b0;
      // Reverse demand follows both requests, one table row at a time
      for (int i = 0; i < 4; i++) begin
         @(posedge i_mclk);
         pd.remote_rev <= i[1];
         pd.run_reverse <= i[0];
         cyc(5);
         `CHK(fl.reverse_demand_flag, i[1] ^ i[0])
      end
      for (int i = 0; i < 3; i++) begin
         @(posedge i_mclk);
         pd[4 + i] <= 1'b1;
         cyc(5);
         `CHK(fl.fan_demand, 1'b1)
         @(posedge i_mclk);
         pd[4 + i] <= 1'b0;
      end
      cyc(590 * T);
      `CHK(fl.fan_demand, 1'b1)
      cyc(12 * T);
      `CHK(fl.fan_demand, 1'b0)
      // Second reset with the frame variant strap set
      @(posedge i_mclk);
      i_reset_n <= 1'b0;
      pd.frame_var <= 1'b1;
      repeat (6) @(posedge i_mclk);
      i_reset_n <= 1'b1;
      cyc(8);
      `CHK(fl, 10'h00C)
      print_verdict();
   end
endmodule
